// *** rtl/status_event_regs.sv ***
// status event register bank: operation and warning groups with transition filters
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// - operation condition readable, within group maximum
// - operation enable mask writable and readable
// - operation event latch readable, within maximum
// - operation falling and rising filters kept separately
// - falling filter bit latches operation falling edge
// - rising filter bit latches operation rising edge
// - both filters zero: operation event untouched
// - warning condition readable, within group maximum
// - warning enable mask writable and readable
// - warning event latch readable, within maximum
// - warning falling and rising filters kept separately
// - falling filter bit latches warning falling edge
// - rising filter bit latches warning rising edge
// - both filters zero: warning event untouched
module status_event_regs
    import status_event_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire bus_req_s      bus,
    input  wire logic [DW-1:0] op_cond_in,
    input  wire logic [DW-1:0] warn_cond_in,
    output logic      [DW-1:0] rdata,
    output logic               op_summary,
    output logic               warn_summary
);

    // ************************************************************
    // group update
    // ************************************************************

    // next value of one group: sync, edge filter, writes, read clear
    function automatic group_s group_next(
        input group_s        g,
        input logic [DW-1:0] pin,
        input logic [DW-1:0] gmax,
        input logic [AW-1:0] base,
        input bus_req_s      b
    );
        group_s        n;
        logic [DW-1:0] agree;
        logic [DW-1:0] edges;
        logic          ok;
        n     = g;
        n.s1  = pin & gmax;
        n.s2  = g.s1;
        n.s3  = g.s2;
        agree = ~(g.s2 ^ g.s3);
        n.cond = (g.cond & ~agree) | (g.s3 & agree);
        // edges pass only where their filter bit is set
        edges = (~g.cond & n.cond & g.rise)
              | (g.cond & ~n.cond & g.fall);
        // values above the group maximum are refused
        ok = b.wr && (b.wdata <= gmax);
        if (ok && b.addr == base + OFS_ENA)
        begin
            n.enable = b.wdata & gmax;
        end
        if (ok && b.addr == base + OFS_FALL)
        begin
            n.fall = b.wdata & gmax;
        end
        if (ok && b.addr == base + OFS_RISE)
        begin
            n.rise = b.wdata & gmax;
        end
        if ((b.rd && b.addr == base + OFS_EVT) || (b.wr && b.addr == CLEAR_ADR))
        begin
            n.event_l = RST_VAL;
        end
        // a new edge wins over a clear in the same cycle
        n.event_l = (n.event_l | edges) & gmax;
        return n;
    endfunction

    // read value of one group, zero when the address is not its own
    function automatic logic [DW-1:0] group_read(
        input group_s        g,
        input logic [AW-1:0] base,
        input logic [AW-1:0] addr
    );
        logic [DW-1:0] v;
        v = RST_VAL;
        if (addr == base + OFS_COND)
        begin
            v = g.cond;
        end
        if (addr == base + OFS_ENA)
        begin
            v = g.enable;
        end
        if (addr == base + OFS_EVT)
        begin
            v = g.event_l;
        end
        if (addr == base + OFS_FALL)
        begin
            v = g.fall;
        end
        if (addr == base + OFS_RISE)
        begin
            v = g.rise;
        end
        return v;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    state_s st_r;
    state_s st_nxt;

    // summary flags from the registered groups
    assign op_summary   = |(st_r.op.event_l & st_r.op.enable);
    assign warn_summary = |(st_r.warn.event_l & st_r.warn.enable);
    assign rdata        = st_r.rdata;

    // next state of the whole bank
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.op    = group_next(st_r.op, op_cond_in, OP_MAX, OP_BASE, bus);
        st_nxt.warn  = group_next(st_r.warn, warn_cond_in, WARN_MAX, WARN_BASE, bus);
        st_nxt.rdata = RST_VAL;
        if (bus.rd)
        begin
            // read data show the content before any clear
            st_nxt.rdata = group_read(st_r.op, OP_BASE, bus.addr)
                         | group_read(st_r.warn, WARN_BASE, bus.addr);
            if (bus.addr == SUMM_ADR)
            begin
                st_nxt.rdata = {14'h0000, warn_summary, op_summary};
            end
        end
    end

    // register the bank
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [DW-1:0] op_edge;
    logic [DW-1:0] warn_edge;
    logic          op_clr;
    logic          warn_clr;
    logic          op_ena_wr;
    logic          op_fall_big;
    logic          op_rise_big;
    logic          warn_ena_wr;
    logic          warn_fall_big;
    logic          warn_rise_big;

    // helper terms for the checks
    assign op_edge     = (~st_r.op.cond & st_nxt.op.cond & st_r.op.rise)
                       | (st_r.op.cond & ~st_nxt.op.cond & st_r.op.fall);
    assign warn_edge   = (~st_r.warn.cond & st_nxt.warn.cond & st_r.warn.rise)
                       | (st_r.warn.cond & ~st_nxt.warn.cond & st_r.warn.fall);
    assign op_clr      = (bus.rd && bus.addr == OP_BASE + OFS_EVT)
                       || (bus.wr && bus.addr == CLEAR_ADR);
    assign warn_clr    = (bus.rd && bus.addr == WARN_BASE + OFS_EVT)
                       || (bus.wr && bus.addr == CLEAR_ADR);
    assign op_ena_wr   = bus.wr && bus.addr == OP_BASE + OFS_ENA && bus.wdata <= OP_MAX;
    assign op_fall_big = bus.wr && bus.addr == OP_BASE + OFS_FALL && bus.wdata > OP_MAX;
    assign op_rise_big = bus.wr && bus.addr == OP_BASE + OFS_RISE && bus.wdata > OP_MAX;
    assign warn_ena_wr = bus.wr && bus.addr == WARN_BASE + OFS_ENA
                       && bus.wdata <= WARN_MAX;
    // out of range writes to the warning filters
    assign warn_fall_big = bus.wr && bus.addr == WARN_BASE + OFS_FALL
                         && bus.wdata > WARN_MAX;
    assign warn_rise_big = bus.wr && bus.addr == WARN_BASE + OFS_RISE
                         && bus.wdata > WARN_MAX;

    // ************************************************************
    // operation group checks
    // ************************************************************

    op_cond_range_a: assert property ((st_r.op.cond & ~OP_MAX) == 16'h0000)
        else $error("operation condition above group maximum");

    // condition bits follow the third stage only where stages agree
    op_cond_sync_a: assert property (((st_r.op.cond ^ $past(st_r.op.s3))
        & ~$past(st_r.op.s2 ^ st_r.op.s3)) == 16'h0000)
        else $error("operation condition did not follow the agreeing stages");

    op_enable_write_a: assert property (op_ena_wr
        |=> st_r.op.enable == ($past(bus.wdata) & OP_MAX))
        else $error("operation enable write not stored");

    op_event_range_a: assert property (st_r.op.event_l <= OP_MAX)
        else $error("operation event above group maximum");

    op_filter_refuse_a: assert property (op_fall_big |=> $stable(st_r.op.fall))
        else $error("operation filter took an out of range value");

    op_rise_refuse_a: assert property (op_rise_big |=> $stable(st_r.op.rise))
        else $error("operation rising filter took an out of range value");

    op_edge_latch_a: assert property ((op_edge != 16'h0000)
        |=> (st_r.op.event_l & $past(op_edge)) == $past(op_edge))
        else $error("operation edge not latched");

    op_quiet_bits_a: assert property (!op_clr |=> ((st_r.op.event_l
        ^ $past(st_r.op.event_l)) & ~$past(st_r.op.fall | st_r.op.rise)) == 16'h0000)
        else $error("operation event changed without filter");

    // latched bits only drop on a clear
    op_event_hold_a: assert property (!op_clr
        |=> ($past(st_r.op.event_l) & ~st_r.op.event_l) == 16'h0000)
        else $error("operation event bit dropped without a clear");

    event_read_clear_a: assert property ((bus.rd
        && bus.addr == OP_BASE + OFS_EVT && op_edge == 16'h0000)
        |=> rdata == $past(st_r.op.event_l)
        && st_r.op.event_l == 16'h0000 && !op_summary)
        else $error("operation event read did not return and clear");

    // ************************************************************
    // warning group checks
    // ************************************************************

    warn_cond_range_a: assert property ((st_r.warn.cond & ~WARN_MAX) == 16'h0000)
        else $error("warning condition above group maximum");

    // condition bits follow the third stage only where stages agree
    warn_cond_sync_a: assert property (((st_r.warn.cond ^ $past(st_r.warn.s3))
        & ~$past(st_r.warn.s2 ^ st_r.warn.s3)) == 16'h0000)
        else $error("warning condition did not follow the agreeing stages");

    warn_enable_write_a: assert property (warn_ena_wr
        |=> st_r.warn.enable == ($past(bus.wdata) & WARN_MAX))
        else $error("warning enable write not stored");

    warn_event_range_a: assert property (st_r.warn.event_l <= WARN_MAX)
        else $error("warning event above group maximum");

    warn_filter_refuse_a: assert property (warn_fall_big |=> $stable(st_r.warn.fall))
        else $error("warning filter took an out of range value");

    warn_rise_refuse_a: assert property (warn_rise_big |=> $stable(st_r.warn.rise))
        else $error("warning rising filter took an out of range value");

    warn_edge_latch_a: assert property ((warn_edge != 16'h0000)
        |=> (st_r.warn.event_l & $past(warn_edge)) == $past(warn_edge))
        else $error("warning edge not latched");

    warn_quiet_bits_a: assert property (!warn_clr |=> ((st_r.warn.event_l
        ^ $past(st_r.warn.event_l)) & ~$past(st_r.warn.fall | st_r.warn.rise)) == 16'h0000)
        else $error("warning event changed without filter");

    // latched bits only drop on a clear
    warn_event_hold_a: assert property (!warn_clr
        |=> ($past(st_r.warn.event_l) & ~st_r.warn.event_l) == 16'h0000)
        else $error("warning event bit dropped without a clear");

    warn_read_clear_a: assert property ((bus.rd
        && bus.addr == WARN_BASE + OFS_EVT && warn_edge == 16'h0000)
        |=> rdata == $past(st_r.warn.event_l)
        && st_r.warn.event_l == 16'h0000 && !warn_summary)
        else $error("warning event read did not return and clear");

    // ************************************************************
    // bus checks
    // ************************************************************

    // read data fall back to zero when no read was taken
    rdata_idle_a: assert property (!bus.rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");

    op_cond_read_a: assert property ((bus.rd && bus.addr == OP_BASE + OFS_COND)
        |=> rdata == $past(st_r.op.cond)) else $error("operation condition read wrong");

    warn_cond_read_a: assert property ((bus.rd && bus.addr == WARN_BASE + OFS_COND)
        |=> rdata == $past(st_r.warn.cond)) else $error("warning condition read wrong");

    summary_read_a: assert property ((bus.rd && bus.addr == SUMM_ADR)
        |=> rdata == {14'h0000, $past(warn_summary), $past(op_summary)})
        else $error("summary register read wrong");

    clear_both_a: assert property ((bus.wr && bus.addr == CLEAR_ADR)
        && op_edge == 16'h0000 && warn_edge == 16'h0000
        |=> st_r.op.event_l == 16'h0000 && st_r.warn.event_l == 16'h0000)
        else $error("clear register left an event bit set");

    // ************************************************************
    // main scenarios
    // ************************************************************

    op_rise_seen_c: cover property (op_edge != 16'h0000 ##1 op_summary);
    warn_read_c: cover property (warn_edge != 16'h0000 ##[1:5] warn_clr);
    set_beats_clear_c: cover property (op_clr && op_edge != 16'h0000);
    refused_write_c: cover property (op_fall_big || op_rise_big
        || warn_fall_big || warn_rise_big);
    summary_read_c: cover property (bus.rd && bus.addr == SUMM_ADR && warn_summary);

endmodule

// *** rtl/status_event_pkg.sv ***
// constants and carrier types for the status event register bank
package status_event_pkg;

    // ************************************************************
    // widths and group limits
    // ************************************************************
    localparam int         DW        = 16;
    localparam int         AW        = 8;
    localparam logic [15:0] OP_MAX   = 16'h5002;  // operation group maximum, 20482
    localparam logic [15:0] WARN_MAX = 16'h7CFF;  // warning group maximum, 31999
    localparam logic [15:0] RST_VAL  = 16'h0000;

    // ************************************************************
    // byte offsets: group base plus register offset
    // ************************************************************
    localparam logic [7:0] OP_BASE   = 8'h00;
    localparam logic [7:0] WARN_BASE = 8'h20;
    localparam logic [7:0] OFS_COND  = 8'h00;
    localparam logic [7:0] OFS_ENA   = 8'h04;
    localparam logic [7:0] OFS_EVT   = 8'h08;
    localparam logic [7:0] OFS_FALL  = 8'h0C;
    localparam logic [7:0] OFS_RISE  = 8'h10;
    localparam logic [7:0] CLEAR_ADR = 8'h40;    // write: clear both event registers
    localparam logic [7:0] SUMM_ADR  = 8'h44;    // read: summary flags in bits 1:0

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } bus_req_s;

    typedef struct packed {
        logic [DW-1:0] s1;
        logic [DW-1:0] s2;
        logic [DW-1:0] s3;
        logic [DW-1:0] cond;
        logic [DW-1:0] enable;
        logic [DW-1:0] event_l;
        logic [DW-1:0] fall;
        logic [DW-1:0] rise;
    } group_s;

    typedef struct packed {
        group_s        op;
        group_s        warn;
        logic [DW-1:0] rdata;
    } state_s;

endpackage

// *** verif/testbench.sv ***
// self-checking bench for the status event register bank
`timescale 1ns/1ps

module testbench;
    import status_event_pkg::*;

    logic          mclk;
    logic          rst;
    bus_req_s      bus;
    logic [DW-1:0] op_pin;
    logic [DW-1:0] warn_pin;
    logic [DW-1:0] rdata;
    logic          op_summary;
    logic          warn_summary;
    int            error_cnt;
    int            checks_done;
    int            g;
    int            k;
    logic [DW-1:0] v;
    logic [AW-1:0] a;

    status_event_regs u_dut (.mclk(mclk), .rst(rst), .bus(bus), .op_cond_in(op_pin),
        .warn_cond_in(warn_pin), .rdata(rdata), .op_summary(op_summary),
        .warn_summary(warn_summary));

    // ****************************************
    // expectation helpers and bus tasks
    // ****************************************
    function automatic logic [7:0] base(int grp);
        return grp ? WARN_BASE : OP_BASE;
    endfunction

    function automatic logic [15:0] gmax(int grp);
        return grp ? WARN_MAX : OP_MAX;
    endfunction

    task automatic wr(logic [7:0] ad, logic [15:0] d);
        @(posedge mclk);
        bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    // one-bit flags seen on the pins
    task automatic fchk(string nm, logic e, logic s);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %b got %b", nm, e, s);
        end
    endtask

    task automatic rchk(string nm, logic [7:0] ad, logic [15:0] e);
        @(posedge mclk);
        bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask

    // pins must settle through the synchroniser before cond and events move
    task automatic pins(int grp, logic [15:0] val);
        @(posedge mclk);
        if (grp)
            warn_pin <= val;
        else
            op_pin <= val;
        repeat (8) @(posedge mclk);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // clock and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        error_cnt++;
        summarize();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        bus = '0;
        op_pin = '0;
        warn_pin = '0;
        error_cnt = 0;
        checks_done = 0;
        v = 16'($urandom(32'h4ABCBABC));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (g = 0; g < 2; g++)
            for (k = 0; k < 5; k++)
                rchk("reset", base(g) + 8'(4 * k), RST_VAL);
        rchk("unmapped", 8'h80, 16'h0000);
        // corner cases: the group maximum is taken, one above it is refused
        for (g = 0; g < 2; g++)
        begin
            wr(base(g) + OFS_RISE, gmax(g));
            rchk("max", base(g) + OFS_RISE, gmax(g));
            wr(base(g) + OFS_RISE, gmax(g) + 16'h0001);
            rchk("max+1", base(g) + OFS_RISE, gmax(g));
        end
        // random writes, then a refused out-of-range write to the same place
        repeat (30)
        begin
            g = $urandom_range(1);
            k = $urandom_range(2);
            a = base(g) + (k == 0 ? OFS_ENA : (k == 1 ? OFS_FALL : OFS_RISE));
            v = 16'($urandom_range(gmax(g)));
            wr(a, v);
            rchk("reg", a, v & gmax(g));
            wr(a, 16'($urandom_range(16'hFFFF, gmax(g) + 1)));
            rchk("refused", a, v & gmax(g));
        end
        for (g = 0; g < 2; g++)
        begin
            wr(base(g) + OFS_ENA, 16'h0000);
            wr(base(g) + OFS_FALL, 16'h0000);
            wr(base(g) + OFS_RISE, 16'h0000);
            wr(CLEAR_ADR, 16'h0000);
            v = 16'($urandom) | 16'h0002;
            pins(g, v);
            rchk("cond", base(g) + OFS_COND, v & gmax(g));
            pins(g, 16'h0000);
            rchk("no filter", base(g) + OFS_EVT, 16'h0000);
            wr(base(g) + OFS_RISE, 16'h0002);
            pins(g, 16'h0002);
            rchk("rise evt", base(g) + OFS_EVT, 16'h0002);
            rchk("rd clear", base(g) + OFS_EVT, 16'h0000);
            pins(g, 16'h0000);
            rchk("fall off", base(g) + OFS_EVT, 16'h0000);
            wr(base(g) + OFS_FALL, 16'h0002);
            pins(g, 16'h0002);
            rchk("both rise", base(g) + OFS_EVT, 16'h0002);
            pins(g, 16'h0000);
            rchk("fall evt", base(g) + OFS_EVT, 16'h0002);
            wr(base(g) + OFS_ENA, 16'h0002);
            pins(g, 16'h0002);
            #1;
            fchk("summary", 1'b1, g ? warn_summary : op_summary);
            rchk("summ reg", SUMM_ADR, g ? 16'h0002 : 16'h0001);
            wr(CLEAR_ADR, 16'h0000);
            #1;
            fchk("summ clr", 1'b0, g ? warn_summary : op_summary);
            pins(g, 16'h0000);
        end
        // reset in mid-run: every register and the warning summary flag go back to zero
        wr(OP_BASE + OFS_ENA, 16'h4000);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (g = 0; g < 2; g++)
            for (k = 0; k < 5; k++)
                rchk("rerst", base(g) + 8'(4 * k), RST_VAL);
        #1;
        fchk("rerst sum", 1'b0, warn_summary);
        summarize();
    end
endmodule
